// [pmi_pkg.sv]
package pmi_pkg;
  localparam logic [7:0] OFS_MODE_SELECT = 8'h3E;
  localparam logic [7:0] OFS_EN_ONE = 8'h40;
  localparam logic [7:0] OFS_EN_TWO = 8'h41;
  localparam logic [7:0] OFS_EN_THREE = 8'h42;
  localparam logic [7:0] OFS_EN_FOUR = 8'h43;
  localparam logic [7:0] OFS_EN_FIVE = 8'h44;
  localparam logic [7:0] OFS_EN_SIX = 8'h45;
  localparam logic [7:0] OFS_ST_SUPPLY = 8'h48;
  localparam logic [7:0] OFS_ST_BATTERY = 8'h49;
  localparam logic [7:0] OFS_ST_TEMP = 8'h4A;
  localparam logic [7:0] OFS_ST_DIE = 8'h4B;
  localparam logic [7:0] OFS_ST_KEY = 8'h4C;
  localparam logic [7:0] OFS_ST_DETECT = 8'h4D;
  localparam logic [7:0] OFS_TS_HIGH = 8'h58;
  localparam logic [7:0] OFS_TS_LOW = 8'h59;
  localparam logic [7:0] OFS_AUX_HIGH = 8'h5A;
  localparam logic [7:0] OFS_AUX_LOW = 8'h5B;
  localparam logic [7:0] RST_MODE_SELECT = 8'h00;
  localparam logic [7:0] RST_EN_ONE = 8'hD8;
  localparam logic [7:0] RST_EN_TWO = 8'hFC;
  localparam logic [7:0] RST_EN_THREE = 8'hFF;
  localparam logic [7:0] RST_EN_FOUR = 8'h03;
  localparam logic [7:0] RST_EN_FIVE = 8'h7C;
  localparam logic [7:0] RST_EN_SIX = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] MODE_REDUCED_SERIAL = 8'h7C;
  localparam logic [7:0] MASK_EN_ONE = 8'hFC;
  localparam logic [7:0] MASK_EN_TWO = 8'hFC;
  localparam logic [7:0] MASK_EN_FOUR = 8'h87;
  localparam logic [7:0] MASK_EN_SIX = 8'h03;
  localparam int BIT_DIE_OVERTEMP = 7;
  localparam int BIT_USB_DETECT = 1;
  localparam int BIT_MULTIVALUE = 0;
  localparam int LV_MAINS = 0;
  localparam int LV_MAINS_OV = 1;
  localparam int LV_VBUS = 2;
  localparam int LV_VBUS_OV = 3;
  localparam int LV_BATTERY = 4;
  localparam int LV_SAFE_MODE = 5;
  localparam int LV_CHARGING = 6;
  localparam int LV_CHARGE_DONE = 7;
  localparam int LV_CHG_OT = 8;
  localparam int LV_CHG_UT = 9;
  localparam int LV_WRK_OT = 10;
  localparam int LV_WRK_UT = 11;
  localparam int LV_DIE_OT = 12;
  localparam int LV_WARN_ONE = 13;
  localparam int LV_WARN_TWO = 14;
  localparam int LV_COUNT = 15;
endpackage

// [pmi_irq_adc.sv]
module pmi_irq_adc
  import pmi_pkg::*;
#(
  parameter int MV_WIDTH = 8,
  parameter int USB_STATE_WIDTH = 8
) (
  // clock and resets
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por,
  // register port behind the serial interface
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reduced_serial_bus_sel,
  // analog condition levels, asynchronous
  input wire logic i_mains_input,
  input wire logic i_mains_overvolt,
  input wire logic i_vbus_valid,
  input wire logic i_vbus_overvolt,
  input wire logic i_battery_present,
  input wire logic i_battery_safe_mode,
  input wire logic i_charging,
  input wire logic i_charge_done,
  input wire logic i_charge_overtemp,
  input wire logic i_charge_undertemp,
  input wire logic i_work_overtemp,
  input wire logic i_work_undertemp,
  input wire logic i_die_overtemp,
  input wire logic i_capacity_warn_one,
  input wire logic i_capacity_warn_two,
  // event pulses from on-chip logic
  input wire logic i_timer_timeout,
  input wire logic i_key_rise_flag,
  input wire logic i_key_fall_flag,
  input wire logic i_key_short_press_flag,
  input wire logic i_key_long_press_flag,
  input wire logic i_key_off_press_flag,
  input wire logic i_pin_one_edge,
  input wire logic i_pin_zero_edge,
  input wire logic i_aux_converter_done,
  // detection state from on-chip logic
  input wire logic [USB_STATE_WIDTH-1:0] i_usb_detect_state_reg,
  input wire logic [MV_WIDTH-1:0] i_multivalue_input_field,
  // conversion results
  input wire logic [11:0] i_temp_sense_result,
  input wire logic i_temp_sense_valid,
  input wire logic [11:0] i_aux_converter_result,
  input wire logic i_aux_converter_valid,
  // interrupt request
  output logic o_irq
);

  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] set,
                                           input logic [7:0] clr);
    // set wins over any clear in the same cycle
    flag_next = (cur & ~clr) | set;
  endfunction

  function automatic logic [7:0] wr_mask(input logic [7:0] addr, input logic wr,
                                         input logic [7:0] ofs, input logic [7:0] data);
    wr_mask = (wr && (addr == ofs)) ? data : 8'h00;
  endfunction

  logic sys_rst;
  assign sys_rst = i_rst | i_por;

  logic [LV_COUNT-1:0] lv_raw;
  logic [LV_COUNT-1:0] lv_meta;
  logic [LV_COUNT-1:0] lv_sync;
  logic [LV_COUNT-1:0] lv_prev;
  logic [LV_COUNT-1:0] lv_rise;
  logic [LV_COUNT-1:0] lv_fall;
  logic [1:0] warm;
  logic primed;

  assign lv_raw = {i_capacity_warn_two, i_capacity_warn_one, i_die_overtemp, i_work_undertemp,
                   i_work_overtemp, i_charge_undertemp, i_charge_overtemp, i_charge_done,
                   i_charging, i_battery_safe_mode, i_battery_present, i_vbus_overvolt,
                   i_vbus_valid, i_mains_overvolt, i_mains_input};

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      lv_meta <= '0;
      lv_sync <= '0;
      lv_prev <= '0;
    end else begin
      lv_meta <= lv_raw;
      lv_sync <= lv_meta;
      lv_prev <= lv_sync;
    end
  end

  // edges are suppressed until the synchroniser and history are filled
  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      warm <= 2'h0;
    end else if (warm != 2'h3) begin
      warm <= warm + 2'h1;
    end
  end

  assign primed = (warm == 2'h3);
  assign lv_rise = primed ? (lv_sync & ~lv_prev) : '0;
  assign lv_fall = primed ? (~lv_sync & lv_prev) : '0;

  logic [7:0] mode_select;
  logic [7:0] en_one;
  logic [7:0] en_two;
  logic [7:0] en_three;
  logic [7:0] en_four;
  logic [7:0] en_five;
  logic [7:0] en_six;

  always_ff @(posedge i_clk) begin
    if (i_por) begin
      mode_select <= RST_MODE_SELECT;
      o_reduced_serial_bus_sel <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == OFS_MODE_SELECT) begin
      mode_select <= i_reg_wdata;
      o_reduced_serial_bus_sel <= (i_reg_wdata == MODE_REDUCED_SERIAL);
    end
  end

  // enables one to four keep their settings across system reset
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      en_one <= RST_EN_ONE;
      en_two <= RST_EN_TWO;
      en_three <= RST_EN_THREE;
      en_four <= RST_EN_FOUR;
    end else if (i_reg_wr) begin
      if (i_reg_addr == OFS_EN_ONE) en_one <= i_reg_wdata & MASK_EN_ONE;
      if (i_reg_addr == OFS_EN_TWO) en_two <= i_reg_wdata & MASK_EN_TWO;
      if (i_reg_addr == OFS_EN_THREE) en_three <= i_reg_wdata;
      if (i_reg_addr == OFS_EN_FOUR) en_four <= i_reg_wdata & MASK_EN_FOUR;
    end
  end

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      en_five <= RST_EN_FIVE;
    end else if (i_reg_wr && i_reg_addr == OFS_EN_FIVE) begin
      en_five <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      en_six <= RST_EN_SIX;
    end else if (i_reg_wr && i_reg_addr == OFS_EN_SIX) begin
      en_six <= i_reg_wdata & MASK_EN_SIX;
    end
  end

  logic [7:0] st_supply;
  logic [7:0] st_battery;
  logic [7:0] st_temp;
  logic [7:0] st_die;
  logic [7:0] st_key;
  logic [7:0] st_detect;
  logic [7:0] set_supply;
  logic [7:0] clr_supply;
  logic [7:0] set_battery;
  logic [7:0] clr_battery;
  logic [7:0] set_temp;
  logic [7:0] clr_temp;
  logic [7:0] set_die;
  logic [7:0] clr_die;
  logic [7:0] set_key;
  logic [7:0] set_detect;
  logic [7:0] next_st_die;

  // supply flags: over-voltage, rise, fall for mains then bus supply
  assign set_supply = {lv_rise[LV_MAINS_OV], lv_rise[LV_MAINS], lv_fall[LV_MAINS],
                       lv_rise[LV_VBUS_OV], lv_rise[LV_VBUS], lv_fall[LV_VBUS], 2'b00};
  assign clr_supply = {lv_fall[LV_MAINS_OV], lv_fall[LV_MAINS], lv_rise[LV_MAINS],
                       lv_fall[LV_VBUS_OV], lv_fall[LV_VBUS], lv_rise[LV_VBUS], 2'b00}
                      | wr_mask(i_reg_addr, i_reg_wr, OFS_ST_SUPPLY, i_reg_wdata);

  assign set_battery = {lv_rise[LV_BATTERY], lv_fall[LV_BATTERY], lv_rise[LV_SAFE_MODE],
                        lv_fall[LV_SAFE_MODE], lv_rise[LV_CHARGING], lv_rise[LV_CHARGE_DONE], 2'b00};
  assign clr_battery = {lv_fall[LV_BATTERY], lv_rise[LV_BATTERY],
                        lv_fall[LV_SAFE_MODE], lv_rise[LV_SAFE_MODE],
                        lv_fall[LV_CHARGING], lv_rise[LV_CHARGING], 2'b00}
                       | wr_mask(i_reg_addr, i_reg_wr, OFS_ST_BATTERY, i_reg_wdata);

  assign set_temp = {lv_rise[LV_CHG_OT], lv_fall[LV_CHG_OT], lv_rise[LV_CHG_UT], lv_fall[LV_CHG_UT],
                     lv_rise[LV_WRK_OT], lv_fall[LV_WRK_OT], lv_rise[LV_WRK_UT], lv_fall[LV_WRK_UT]};
  assign clr_temp = {lv_fall[LV_CHG_OT], lv_rise[LV_CHG_OT], lv_fall[LV_CHG_UT], lv_rise[LV_CHG_UT],
                     lv_fall[LV_WRK_OT], lv_rise[LV_WRK_OT], lv_fall[LV_WRK_UT], lv_rise[LV_WRK_UT]}
                    | wr_mask(i_reg_addr, i_reg_wr, OFS_ST_TEMP, i_reg_wdata);

  assign set_die = {lv_rise[LV_DIE_OT], 4'h0, i_aux_converter_done, lv_rise[LV_WARN_ONE],
                    lv_rise[LV_WARN_TWO]};
  // converter done has no automatic clear term
  assign clr_die = {lv_fall[LV_DIE_OT], 4'h0, 1'b0, lv_fall[LV_WARN_ONE], lv_fall[LV_WARN_TWO]}
                   | wr_mask(i_reg_addr, i_reg_wr, OFS_ST_DIE, i_reg_wdata);
  assign next_st_die = flag_next(st_die, set_die, clr_die);

  assign set_key = {i_timer_timeout, i_key_rise_flag, i_key_fall_flag, i_key_short_press_flag,
                    i_key_long_press_flag, i_key_off_press_flag, i_pin_one_edge, i_pin_zero_edge};

  always_ff @(posedge i_clk) begin
    if (i_por) begin
      st_supply <= RST_STATUS;
      st_battery <= RST_STATUS;
    end else begin
      st_supply <= flag_next(st_supply, set_supply, clr_supply);
      st_battery <= flag_next(st_battery, set_battery, clr_battery);
    end
  end

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      st_temp <= RST_STATUS;
    end else begin
      st_temp <= flag_next(st_temp, set_temp, clr_temp);
    end
  end

  // die flag survives system reset, the lower bits do not
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      st_die <= RST_STATUS;
    end else if (i_rst) begin
      st_die <= {next_st_die[BIT_DIE_OVERTEMP], RST_STATUS[6:0]};
    end else begin
      st_die <= next_st_die;
    end
  end

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      st_key <= RST_STATUS;
    end else begin
      st_key <= flag_next(st_key, set_key, wr_mask(i_reg_addr, i_reg_wr, OFS_ST_KEY, i_reg_wdata));
    end
  end

  logic [USB_STATE_WIDTH-1:0] usb_state_prev;
  logic [MV_WIDTH-1:0] mv_prev;

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      usb_state_prev <= '0;
      mv_prev <= '0;
    end else begin
      usb_state_prev <= i_usb_detect_state_reg;
      mv_prev <= i_multivalue_input_field;
    end
  end

  assign set_detect = {6'h00,
                       primed && (i_usb_detect_state_reg != usb_state_prev),
                       primed && (i_multivalue_input_field != mv_prev)};

  // bus supply falling edge acts as a reset and beats a simultaneous change event
  always_ff @(posedge i_clk) begin
    if (i_por || lv_fall[LV_VBUS]) begin
      st_detect <= RST_STATUS;
    end else begin
      st_detect <= flag_next(st_detect, set_detect,
                             wr_mask(i_reg_addr, i_reg_wr, OFS_ST_DETECT, i_reg_wdata));
    end
  end

  logic [11:0] ts_result;
  logic [11:0] aux_result;

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      ts_result <= 12'h000;
    end else if (i_temp_sense_valid) begin
      ts_result <= i_temp_sense_result;
    end
  end

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      aux_result <= 12'h000;
    end else if (i_aux_converter_valid) begin
      aux_result <= i_aux_converter_result;
    end
  end

  logic [7:0] read_value;

  always_comb begin
    case (i_reg_addr)
      OFS_MODE_SELECT: read_value = mode_select;
      OFS_EN_ONE: read_value = en_one;
      OFS_EN_TWO: read_value = en_two;
      OFS_EN_THREE: read_value = en_three;
      OFS_EN_FOUR: read_value = en_four;
      OFS_EN_FIVE: read_value = en_five;
      OFS_EN_SIX: read_value = en_six;
      OFS_ST_SUPPLY: read_value = st_supply;
      OFS_ST_BATTERY: read_value = st_battery;
      OFS_ST_TEMP: read_value = st_temp;
      OFS_ST_DIE: read_value = st_die;
      OFS_ST_KEY: read_value = st_key;
      OFS_ST_DETECT: read_value = st_detect;
      OFS_TS_HIGH: read_value = ts_result[11:4];
      OFS_TS_LOW: read_value = {4'h0, ts_result[3:0]};
      OFS_AUX_HIGH: read_value = aux_result[11:4];
      OFS_AUX_LOW: read_value = {4'h0, aux_result[3:0]};
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= read_value;
    end
  end

  logic [7:0] pend;

  assign pend = (st_supply & en_one) | (st_battery & en_two) | (st_temp & en_three)
                | (st_die & en_four) | (st_key & en_five) | (st_detect & en_six);
  assign o_irq = |pend;

  a_en_five_reset: assert property (@(posedge i_clk) $fell(sys_rst) |-> en_five == 8'h7C)
    else $error("enable five not at reset value after reset");

  a_en_six_reserved: assert property (@(posedge i_clk) disable iff (sys_rst) en_six[7:2] == 6'h00)
    else $error("enable six reserved bits set");

  a_mains_ov_clear: assert property (@(posedge i_clk) disable iff (sys_rst)
    lv_fall[LV_MAINS_OV] |=> !st_supply[7])
    else $error("mains over-voltage flag kept after return to normal");

  a_mains_rise_swap: assert property (@(posedge i_clk) disable iff (sys_rst)
    lv_rise[LV_MAINS] |=> st_supply[6] && !st_supply[5])
    else $error("mains rise did not set rise and clear fall");

  a_battery_swap: assert property (@(posedge i_clk) disable iff (sys_rst)
    lv_fall[LV_BATTERY] |=> st_battery[6] && !st_battery[7])
    else $error("battery removal did not set absent and clear attached");

  a_vbus_fall_wipe: assert property (@(posedge i_clk) disable iff (i_por)
    lv_fall[LV_VBUS] |=> st_detect == 8'h00 && !(|(st_detect & en_six)))
    else $error("status six not cleared by bus supply fall");

  a_key_w1c_clear: assert property (@(posedge i_clk) disable iff (sys_rst)
    (i_reg_wr && i_reg_addr == OFS_ST_KEY && i_reg_wdata[6] && !i_key_rise_flag) |=> !st_key[6])
    else $error("key rise flag not cleared by write one");

  a_key_no_autoclr: assert property (@(posedge i_clk) disable iff (sys_rst)
    !(i_reg_wr && i_reg_addr == OFS_ST_KEY) |=> (($past(st_key) & ~st_key) == 8'h00))
    else $error("key flag lost without a write of one");

  a_mv_change_set: assert property (@(posedge i_clk) disable iff (sys_rst)
    (primed && $changed(i_multivalue_input_field) && !lv_fall[LV_VBUS]) ##1 !lv_fall[LV_VBUS]
    |-> ##1 st_detect[BIT_MULTIVALUE])
    else $error("multivalue change did not set its flag");

  a_aux_low_nibble: assert property (@(posedge i_clk) disable iff (sys_rst)
    (i_reg_rd && i_reg_addr == OFS_AUX_LOW) |=> o_reg_rdata == {4'h0, aux_result[3:0]})
    else $error("converter low register read wrong");

  a_die_por_only: assert property (@(posedge i_clk) disable iff (i_por)
    (i_rst && !lv_fall[LV_DIE_OT]) |=> st_die[BIT_DIE_OVERTEMP] == $past(st_die[BIT_DIE_OVERTEMP])
      && st_die[6:0] == 7'h00)
    else $error("die over-temperature flag disturbed by system reset");

  a_irq_release: assert property (@(posedge i_clk) disable iff (sys_rst)
    (pend == 8'h00) [*2] |-> !o_irq)
    else $error("interrupt held without pending flag");

endmodule

// [pmi_host.sv]
module pmi_host (
  // clock
  input wire logic i_clk,
  // register port
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // one write, then data is scrambled so nothing stale lingers
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_clk);
    o_reg_wr <= 1'b0;
    o_reg_wdata <= ~d;
  endtask

  // read data is registered, valid the cycle after the taken edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_clk);
    o_reg_rd <= 1'b0;
    #1;
    d = i_reg_rdata;
  endtask
endmodule

// [tb_pmi_irq_adc.sv]
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end

module tb_pmi_irq_adc;
  import pmi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst, por, wr, rd, sel, irq, adc_done, ts_v, aux_v;
  logic [7:0] addr, wdata, rdata, ev, usb_st, mv;
  logic [LV_COUNT-1:0] lv;
  logic [11:0] ts_res, aux_res;
  int fail_count = 0;
  int n_tests = 0;

  pmi_host host (.i_clk(clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata),
    .i_reg_rdata(rdata));

  pmi_irq_adc dut (.i_clk(clk), .i_rst(rst), .i_por(por), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reduced_serial_bus_sel(sel),
    .i_mains_input(lv[LV_MAINS]), .i_mains_overvolt(lv[LV_MAINS_OV]), .i_vbus_valid(lv[LV_VBUS]),
    .i_vbus_overvolt(lv[LV_VBUS_OV]), .i_battery_present(lv[LV_BATTERY]), .i_battery_safe_mode(lv[LV_SAFE_MODE]),
    .i_charging(lv[LV_CHARGING]), .i_charge_done(lv[LV_CHARGE_DONE]), .i_charge_overtemp(lv[LV_CHG_OT]),
    .i_charge_undertemp(lv[LV_CHG_UT]), .i_work_overtemp(lv[LV_WRK_OT]), .i_work_undertemp(lv[LV_WRK_UT]),
    .i_die_overtemp(lv[LV_DIE_OT]), .i_capacity_warn_one(lv[LV_WARN_ONE]), .i_capacity_warn_two(lv[LV_WARN_TWO]),
    .i_timer_timeout(ev[7]), .i_key_rise_flag(ev[6]), .i_key_fall_flag(ev[5]), .i_key_short_press_flag(ev[4]),
    .i_key_long_press_flag(ev[3]), .i_key_off_press_flag(ev[2]), .i_pin_one_edge(ev[1]), .i_pin_zero_edge(ev[0]),
    .i_aux_converter_done(adc_done), .i_usb_detect_state_reg(usb_st), .i_multivalue_input_field(mv),
    .i_temp_sense_result(ts_res), .i_temp_sense_valid(ts_v), .i_aux_converter_result(aux_res),
    .i_aux_converter_valid(aux_v), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.read_reg(a, d);
    `CHK(d, e)
  endtask

  // level inputs pass a 2-flop sync, so allow settling time
  task automatic set_lv(input int i, input logic v);
    @(posedge clk) lv[i] <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_reset_values();
    rd_chk(OFS_EN_FIVE, RST_EN_FIVE);
    rd_chk(OFS_EN_SIX, RST_EN_SIX);
    rd_chk(OFS_ST_KEY, RST_STATUS);
    rd_chk(8'h50, 8'h00);
  endtask

  task automatic t_key_events();
    for (int b = 0; b < 8; b++) begin
      @(posedge clk) ev[b] <= 1'b1;
      @(posedge clk) ev[b] <= 1'b0;
      #1;
      `CHK(irq, RST_EN_FIVE[b])
      host.write_reg(OFS_ST_KEY, 8'h00);
      rd_chk(OFS_ST_KEY, 8'h01 << b);
      host.write_reg(OFS_ST_KEY, 8'h01 << b);
      rd_chk(OFS_ST_KEY, 8'h00);
      `CHK(irq, 1'b0)
    end
  endtask

  task automatic t_supply();
    set_lv(LV_MAINS, 1'b1);
    rd_chk(OFS_ST_SUPPLY, 8'h40);
    `CHK(irq, 1'b1)
    set_lv(LV_MAINS, 1'b0);
    rd_chk(OFS_ST_SUPPLY, 8'h20);
    `CHK(irq, 1'b0)
    host.write_reg(OFS_ST_SUPPLY, 8'h20);
    set_lv(LV_MAINS_OV, 1'b1);
    rd_chk(OFS_ST_SUPPLY, 8'h80);
    set_lv(LV_MAINS_OV, 1'b0);
    rd_chk(OFS_ST_SUPPLY, 8'h00);
    set_lv(LV_VBUS_OV, 1'b1);
    rd_chk(OFS_ST_SUPPLY, 8'h10);
    set_lv(LV_VBUS_OV, 1'b0);
    set_lv(LV_VBUS, 1'b1);
    rd_chk(OFS_ST_SUPPLY, 8'h08);
    host.write_reg(OFS_ST_SUPPLY, 8'h08);
    set_lv(LV_CHG_OT, 1'b1);
    rd_chk(OFS_ST_TEMP, 8'h80);
    set_lv(LV_CHG_OT, 1'b0);
    rd_chk(OFS_ST_TEMP, 8'h40);
    set_lv(LV_WRK_UT, 1'b1);
    rd_chk(OFS_ST_TEMP, 8'h42);
    set_lv(LV_WRK_UT, 1'b0);
    rd_chk(OFS_ST_TEMP, 8'h41);
    host.write_reg(OFS_ST_TEMP, 8'hFF);
  endtask

  task automatic t_battery();
    host.write_reg(OFS_EN_TWO, 8'hFF);
    rd_chk(OFS_EN_TWO, 8'hFC);
    set_lv(LV_BATTERY, 1'b1);
    rd_chk(OFS_ST_BATTERY, 8'h80);
    `CHK(irq, 1'b1)
    host.write_reg(OFS_EN_TWO, 8'h00);
    #1;
    `CHK(irq, 1'b0)
    set_lv(LV_BATTERY, 1'b0);
    rd_chk(OFS_ST_BATTERY, 8'h40);
    set_lv(LV_SAFE_MODE, 1'b1);
    rd_chk(OFS_ST_BATTERY, 8'h60);
    set_lv(LV_SAFE_MODE, 1'b0);
    rd_chk(OFS_ST_BATTERY, 8'h50);
    set_lv(LV_CHARGING, 1'b1);
    set_lv(LV_CHARGE_DONE, 1'b1);
    rd_chk(OFS_ST_BATTERY, 8'h5C);
    set_lv(LV_CHARGING, 1'b0);
    rd_chk(OFS_ST_BATTERY, 8'h54);
    set_lv(LV_CHARGING, 1'b1);
    rd_chk(OFS_ST_BATTERY, 8'h58);
    host.write_reg(OFS_ST_BATTERY, 8'hFF);
    rd_chk(OFS_ST_BATTERY, 8'h00);
  endtask

  task automatic t_detect();
    host.write_reg(OFS_EN_SIX, 8'hFF);
    rd_chk(OFS_EN_SIX, 8'h03);
    @(posedge clk) usb_st <= 8'h5A;
    repeat (3) @(posedge clk);
    #1;
    `CHK(irq, 1'b1)
    @(posedge clk) mv <= 8'h33;
    rd_chk(OFS_ST_DETECT, 8'h03);
    host.write_reg(OFS_ST_DETECT, 8'h02);
    rd_chk(OFS_ST_DETECT, 8'h01);
    `CHK(irq, 1'b1)
    host.write_reg(OFS_ST_DETECT, 8'h01);
    #1;
    `CHK(irq, 1'b0)
    @(posedge clk) usb_st <= 8'hA5;
    set_lv(LV_VBUS, 1'b0);
    rd_chk(OFS_ST_DETECT, 8'h00);
    rd_chk(OFS_ST_SUPPLY, 8'h04);
  endtask

  task automatic t_results();
    @(posedge clk) begin
      ts_res <= 12'hABC;
      aux_res <= 12'h5E7;
      ts_v <= 1'b1;
      aux_v <= 1'b1;
      adc_done <= 1'b1;
    end
    @(posedge clk) begin
      ts_v <= 1'b0;
      aux_v <= 1'b0;
      adc_done <= 1'b0;
    end
    rd_chk(OFS_TS_HIGH, 8'hAB);
    host.write_reg(OFS_TS_LOW, 8'hFF);
    rd_chk(OFS_TS_LOW, 8'h0C);
    rd_chk(OFS_AUX_HIGH, 8'h5E);
    rd_chk(OFS_AUX_LOW, 8'h07);
    set_lv(LV_WARN_ONE, 1'b1);
    rd_chk(OFS_ST_DIE, 8'h06);
    set_lv(LV_WARN_TWO, 1'b1);
    rd_chk(OFS_ST_DIE, 8'h07);
    set_lv(LV_WARN_ONE, 1'b0);
    rd_chk(OFS_ST_DIE, 8'h05);
    set_lv(LV_WARN_TWO, 1'b0);
    rd_chk(OFS_ST_DIE, 8'h04);
    host.write_reg(OFS_ST_DIE, 8'h04);
    rd_chk(OFS_ST_DIE, 8'h00);
  endtask

  task automatic t_sys_reset();
    set_lv(LV_DIE_OT, 1'b1);
    host.write_reg(OFS_EN_FIVE, 8'h00);
    host.write_reg(OFS_MODE_SELECT, MODE_REDUCED_SERIAL);
    #1;
    `CHK(sel, 1'b1)
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_ST_DIE, 8'h80);
    rd_chk(OFS_EN_FIVE, RST_EN_FIVE);
    host.write_reg(OFS_MODE_SELECT, 8'h7D);
    #1;
    `CHK(sel, 1'b0)
    @(posedge clk) por <= 1'b1;
    @(posedge clk) por <= 1'b0;
    rd_chk(OFS_ST_DIE, 8'h00);
    rd_chk(OFS_EN_TWO, RST_EN_TWO);
    rd_chk(OFS_MODE_SELECT, RST_MODE_SELECT);
  endtask

  initial begin
    rst = 1'b1;
    por = 1'b1;
    lv = '0;
    ev = 8'h00;
    adc_done = 1'b0;
    usb_st = 8'h00;
    mv = 8'h00;
    ts_res = 12'h000;
    aux_res = 12'h000;
    ts_v = 1'b0;
    aux_v = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset_values();
    t_key_events();
    t_supply();
    t_detect();
    t_battery();
    t_results();
    t_sys_reset();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule
